// >>> fbr_pkg.sv
// Purpose: Shared constants, types and helpers for the fieldbus RAM parameter block.
// Assumes: 3 Kbyte internal RAM, 8-bit host port, 10 host address lines.
// Notes:   Segment size is 8 bytes in compatibility mode and 16 in extended mode.
package fbr_pkg;

    // ==========================================================================
    // Memory size and host address windows
    // ==========================================================================
    localparam int        RAM_BYTES   = 3072;
    localparam logic [1:0] WIN_PARAM0 = 2'h0;
    localparam logic [1:0] WIN_PARAM1 = 2'h1;
    localparam logic [1:0] WIN_BASE   = 2'h2;
    localparam logic [1:0] WIN_REGS   = 2'h3;

    // ==========================================================================
    // RAM parameter block offsets
    // ==========================================================================
    localparam logic [11:0] OFS_WRITE_PTR  = 12'h001;
    localparam logic [11:0] OFS_NODE_ADDR  = 12'h004;
    localparam logic [11:0] OFS_HIGHEST_ACCESS_POINT_NUMBER    = 12'h005;
    localparam logic [11:0] OFS_CYC_MASTER = 12'h006;
    localparam logic [11:0] OFS_GRP_SELECT = 12'h007;
    localparam logic [11:0] OFS_WORK_LO    = 12'h008;
    localparam logic [11:0] OFS_WORK_HI    = 12'h017;

    // ==========================================================================
    // Service access point area layout
    // ==========================================================================
    localparam logic [11:0] SAP_LO        = 12'h018;
    localparam logic [11:0] SAP_HI        = 12'h180;
    localparam int          SAP_BYTES     = 361;
    localparam int          SYSTEM_MGMT_ACCESS_POINTS_COUNT  = 5;
    localparam int          SYSTEM_MGMT_ACCESS_POINTS_LEN    = 5;
    localparam int          FALLBACK_LEN  = 16;
    localparam int          SAP_COUNT     = 64;
    localparam int          SAP_LEN       = 5;
    localparam logic [11:0] FALLBACK_BASE = 12'h031;
    localparam logic [11:0] SAP_ENTRY_BASE = 12'h041;

    // ==========================================================================
    // Indication queue placement and segment sizes
    // ==========================================================================
    localparam logic [11:0] QSTART_COMPAT    = 12'h188;
    localparam logic [11:0] QSTART_EXT       = 12'h190;
    localparam int          SEG_SHIFT_COMPAT = 3;
    localparam int          SEG_SHIFT_EXT    = 4;

    // ==========================================================================
    // Parameter register offsets inside the register window
    // ==========================================================================
    localparam logic [5:0] PREG_BEGIN = 6'h20;
    localparam logic [5:0] PREG_LIMIT = 6'h21;
    localparam logic [5:0] PREG_BASE  = 6'h22;
    localparam logic [7:0] PTR_RESET  = 8'h00;

    // ==========================================================================
    // Node address classes for the two bus variants
    // ==========================================================================
    localparam logic [7:0] NODE_PA_NORMAL_MAX = 8'h77;
    localparam logic [7:0] NODE_PA_TEMP_MAX   = 8'h7C;
    localparam logic [7:0] NODE_PA_TEMP_DEF   = 8'h7D;
    localparam logic [7:0] NODE_PA_PERM_DEF   = 8'h7E;
    localparam logic [7:0] NODE_DP_NORMAL_MAX = 8'h7D;
    localparam logic [7:0] NODE_DP_ASSIGN     = 8'h7E;
    localparam logic [7:0] NODE_BCAST         = 8'h7F;
    localparam logic [7:0] NODE_DP_SLAVE_MIN  = 8'h03;

    typedef enum logic [2:0] {
        NC_NORMAL     = 3'h0,
        NC_TEMP       = 3'h1,
        NC_TEMP_DEF   = 3'h2,
        NC_PERM_DEF   = 3'h3,
        NC_ASSIGN_DEF = 3'h4,
        NC_BCAST      = 3'h5,
        NC_INVALID    = 3'h6
    } fbr_node_class_e;

    // Segment pointer to byte address, scaled by the mode's segment size.
    function automatic logic [11:0] fbr_seg_to_addr(input logic [7:0] ptr,
                                                    input logic       ext);
        fbr_seg_to_addr = ext ? {ptr, 4'h0} : {1'b0, ptr, 3'h0};
    endfunction : fbr_seg_to_addr

    // Classify a node address for the process automation or periphery variant.
    function automatic fbr_node_class_e fbr_node_class(input logic [7:0] a,
                                                       input logic       pa);
        if (a > NODE_BCAST) begin
            fbr_node_class = NC_INVALID;
        end else if (a == NODE_BCAST) begin
            fbr_node_class = NC_BCAST;
        end else if (pa) begin
            if (a <= NODE_PA_NORMAL_MAX) fbr_node_class = NC_NORMAL;
            else if (a <= NODE_PA_TEMP_MAX) fbr_node_class = NC_TEMP;
            else if (a == NODE_PA_TEMP_DEF) fbr_node_class = NC_TEMP_DEF;
            else fbr_node_class = NC_PERM_DEF;
        end else begin
            if (a <= NODE_DP_NORMAL_MAX) fbr_node_class = NC_NORMAL;
            else fbr_node_class = NC_ASSIGN_DEF;
        end
    endfunction : fbr_node_class

endpackage : fbr_pkg

// >>> fbr_wr_check.sv
// Purpose: Write protection and area decode for one physical RAM byte address.
// Assumes: Address already resolved from the host window to a RAM address.
// Notes:   Purely combinational; the caller registers whatever it exposes.
`timescale 1ns/1ps
module fbr_wr_check (
    input  wire logic [11:0] phys_addr,
    input  wire logic        is_ram,
    input  wire logic        extended,
    output logic             violation,
    output logic             sap_area
);

    // ==========================================================================
    // Protected cells
    // ==========================================================================
    // Work cells are always protected; the two extended-mode bytes only exist
    // in extended mode, so compatibility mode treats a write there as a fault.
    always_comb begin
        violation = 1'b0;
        if (is_ram && phys_addr >= fbr_pkg::OFS_WORK_LO
                   && phys_addr <= fbr_pkg::OFS_WORK_HI) begin
            violation = 1'b1;
        end
        if (is_ram && !extended && (phys_addr == fbr_pkg::OFS_CYC_MASTER
                                 || phys_addr == fbr_pkg::OFS_GRP_SELECT)) begin
            violation = 1'b1;
        end
    end

    // The access point list is reached directly, without the base pointer.
    assign sap_area = is_ram && phys_addr >= fbr_pkg::SAP_LO
                             && phys_addr <= fbr_pkg::SAP_HI;

endmodule : fbr_wr_check

// >>> fbr_ram_block.sv
// Purpose: Internal RAM with parameter block, write checks and queue pointers.
// Assumes: Host pins are asynchronous and are held until ready is returned.
// Notes:   Strap-like mode pins are resynchronised like the host pins; ind_step and online_req are not.
//
// Contract
// - PA: 120-124 temporary, 125 temporary default
// - PA: 126 permanent default, 127 broadcast
// - DP: 0-125 normal stations, slaves from 3
// - DP: 126 reserved for address assignment
// - Byte 05H holds highest access point number
// - Byte 06H holds cycle master station address
// - Byte 07H holds clock sync group select
// - Host writes to 08H-17H violate
// - Access point list directly addressable
// - Access point area is 18H to 180H
// - Five management, one fallback, 64 entries
// - Queue start at least 188H or 190H
// - Begin pointer marks first queue segment
// - Limit pointer is first segment past queue
// - Segments are 8 or 16 bytes
// - Write pointer wraps from limit to begin
`timescale 1ns/1ps
module fbr_ram_block (
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    input  wire logic       chip_select_n,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic [9:0] addr,
    input  wire logic [7:0] data_in,
    input  wire logic       extended_mode,
    input  wire logic       pa_variant,
    input  wire logic       ind_step,
    input  wire logic       online_req,
    output logic      [7:0] data_out,
    output logic            data_oe,
    output logic            access_ready_n,
    output logic      [7:0] queue_write_pointer,
    output logic            write_violation,
    output logic            offline,
    output logic      [2:0] node_class,
    output logic            queue_place_error,
    output logic            sap_access
);

    // ==========================================================================
    // Types and state
    // ==========================================================================
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_HOLD = 3'b100
    } fbr_st_e;

    // Pin bundle order: cs, rd, wr, addr, data, extended, pa.
    localparam int PW = 23;

    typedef struct packed {
        logic [PW-1:0] pin_m;
        logic [PW-1:0] pin_q;
        fbr_st_e       st;
        logic [7:0]    dout;
        logic          oe;
        logic          rdy_n;
        logic [7:0]    wp;
        logic [7:0]    begin_p;
        logic [7:0]    limit_p;
        logic [7:0]    base_p;
        logic          viol;
        logic          offline;
        logic [2:0]    ncls;
        logic          qerr;
        logic          sap;
    } fbr_state_s;

    fbr_state_s s_r;
    fbr_state_s s_nxt;

    // The memory is kept out of the state struct so it maps onto a RAM macro.
    logic [7:0] ram [0:fbr_pkg::RAM_BYTES-1];

    // ==========================================================================
    // Synchronised pin views
    // ==========================================================================
    logic       cs_q;
    logic       rd_q;
    logic       wr_q;
    logic [9:0] a_q;
    logic [7:0] d_q;
    logic       ext_q;
    logic       pa_q;

    assign {cs_q, rd_q, wr_q, a_q, d_q, ext_q, pa_q} = s_r.pin_q;

    // ==========================================================================
    // Address resolution
    // ==========================================================================
    logic [11:0] phys;
    logic        is_ram;
    logic        in_range;
    logic [7:0]  ram_rd;
    logic        viol_c;
    logic        sap_c;
    logic        ram_we;
    logic [7:0]  wp_inc;

    // The base window scales the pointer by the segment size of the mode.
    always_comb begin
        phys = {4'h0, a_q[7:0]};
        is_ram = 1'b1;
        case (a_q[9:8])
            fbr_pkg::WIN_PARAM0: phys = {4'h0, a_q[7:0]};
            fbr_pkg::WIN_PARAM1: phys = {4'h1, a_q[7:0]};
            fbr_pkg::WIN_BASE:   phys = fbr_pkg::fbr_seg_to_addr(s_r.base_p, ext_q)
                                        + {4'h0, a_q[7:0]};
            default:             is_ram = 1'b0;
        endcase
    end

    // Bytes above the end of the RAM read as zero and ignore writes.
    assign in_range = is_ram && (phys < 12'(fbr_pkg::RAM_BYTES));
    assign ram_rd   = in_range ? ram[phys] : 8'h00;
    assign wp_inc   = s_r.wp + 8'h01;

    fbr_wr_check u_check (
        .phys_addr (phys),
        .is_ram    (in_range),
        .extended  (ext_q),
        .violation (viol_c),
        .sap_area  (sap_c)
    );

    // A write commits only when it passes the protection check.
    assign ram_we = (s_r.st == ST_EXEC) && !wr_q && in_range && !viol_c;

    // ==========================================================================
    // Next-state logic
    // ==========================================================================
    always_comb begin
        s_nxt       = s_r;
        s_nxt.pin_m = {chip_select_n, rd_n, wr_n, addr, data_in, extended_mode, pa_variant};
        s_nxt.pin_q = s_r.pin_m;
        s_nxt.viol  = 1'b0;

        // Node class tracks the live RAM contents; queue placement tracks the begin pointer.
        s_nxt.ncls = fbr_pkg::fbr_node_class(ram[fbr_pkg::OFS_NODE_ADDR], pa_q);
        s_nxt.qerr = fbr_pkg::fbr_seg_to_addr(s_r.begin_p, ext_q)
                     < (ext_q ? fbr_pkg::QSTART_EXT : fbr_pkg::QSTART_COMPAT);

        // The write pointer walks one segment per step and wraps at the limit.
        if (ind_step && !s_r.offline) begin
            s_nxt.wp = (wp_inc == s_r.limit_p) ? s_r.begin_p : wp_inc;
        end

        case (s_r.st)
            ST_IDLE: begin
                // Chip select must qualify every strobe before an access starts.
                if (!cs_q && (!rd_q || !wr_q)) begin
                    s_nxt.st = ST_EXEC;
                end
            end
            ST_EXEC: begin
                s_nxt.st    = ST_HOLD;
                s_nxt.rdy_n = 1'b0;
                s_nxt.sap   = sap_c;
                if (!wr_q) begin
                    if (!is_ram) begin
                        case (a_q[5:0])
                            fbr_pkg::PREG_BEGIN: s_nxt.begin_p = d_q;
                            fbr_pkg::PREG_LIMIT: s_nxt.limit_p = d_q;
                            fbr_pkg::PREG_BASE:  s_nxt.base_p  = d_q;
                            default: ;
                        endcase
                    end else if (viol_c) begin
                        // A protected write faults and takes the device offline.
                        s_nxt.viol    = 1'b1;
                        s_nxt.offline = 1'b1;
                    end else if (phys == fbr_pkg::OFS_WRITE_PTR) begin
                        s_nxt.wp = d_q;
                    end
                end else begin
                    s_nxt.oe = 1'b1;
                    if (!is_ram) begin
                        case (a_q[5:0])
                            fbr_pkg::PREG_BEGIN: s_nxt.dout = s_r.begin_p;
                            fbr_pkg::PREG_LIMIT: s_nxt.dout = s_r.limit_p;
                            fbr_pkg::PREG_BASE:  s_nxt.dout = s_r.base_p;
                            default:             s_nxt.dout = 8'h00;
                        endcase
                    end else if (phys == fbr_pkg::OFS_WRITE_PTR) begin
                        s_nxt.dout = s_r.wp;
                    end else begin
                        s_nxt.dout = ram_rd;
                    end
                end
            end
            ST_HOLD: begin
                // Ready stays low until the host ends the cycle.
                if (cs_q || (rd_q && wr_q)) begin
                    s_nxt.st    = ST_IDLE;
                    s_nxt.rdy_n = 1'b1;
                    s_nxt.oe    = 1'b0;
                end
            end
            default: begin
                s_nxt.st    = ST_IDLE;
                s_nxt.rdy_n = 1'b1;
                s_nxt.oe    = 1'b0;
            end
        endcase

        // A fault in the same cycle as a go-online request keeps it offline.
        if (online_req && !s_nxt.viol) begin
            s_nxt.offline = 1'b0;
        end
    end

    // ==========================================================================
    // State register
    // ==========================================================================
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s_r         <= '0;
            s_r.pin_m   <= '1;
            s_r.pin_q   <= '1;
            s_r.st      <= ST_IDLE;
            s_r.rdy_n   <= 1'b1;
            s_r.offline <= 1'b1;
            s_r.wp      <= fbr_pkg::PTR_RESET;
            s_r.begin_p <= fbr_pkg::PTR_RESET;
            s_r.limit_p <= fbr_pkg::PTR_RESET;
            s_r.base_p  <= fbr_pkg::PTR_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // RAM write port; contents are undefined after power-up, as in the part.
    always_ff @(posedge ref_clk) begin
        if (ram_we) begin
            ram[phys] <= d_q;
        end
    end

    // ==========================================================================
    // Outputs
    // ==========================================================================
    assign data_out            = s_r.dout;
    assign data_oe             = s_r.oe;
    assign access_ready_n      = s_r.rdy_n;
    assign queue_write_pointer = s_r.wp;
    assign write_violation     = s_r.viol;
    assign offline             = s_r.offline;
    assign node_class          = s_r.ncls;
    assign queue_place_error   = s_r.qerr;
    assign sap_access          = s_r.sap;

    // ==========================================================================
    // Assertions
    // ==========================================================================
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    property p_work_cells;
        s_r.st == ST_EXEC && !wr_q && is_ram && in_range
            && phys >= fbr_pkg::OFS_WORK_LO && phys <= fbr_pkg::OFS_WORK_HI
            |=> write_violation && offline;
    endproperty
    a_work_cells: assert property (p_work_cells) else $error("work cell write not flagged");

    property p_compat_ext_bytes;
        s_r.st == ST_EXEC && !wr_q && !ext_q && a_q[9:8] == fbr_pkg::WIN_PARAM0
            && (a_q[7:0] == 8'h06 || a_q[7:0] == 8'h07) |=> write_violation;
    endproperty
    a_compat_ext_bytes: assert property (p_compat_ext_bytes) else $error("compat write missed");

    property p_ext_write;
        s_r.st == ST_EXEC && !wr_q && ext_q && a_q == 10'h006
            |=> !write_violation && ram[fbr_pkg::OFS_CYC_MASTER] == $past(d_q);
    endproperty
    a_ext_write: assert property (p_ext_write) else $error("cycle master byte not stored");

    property p_protect;
        s_r.st == ST_EXEC && !wr_q && in_range && viol_c |=> ram[$past(phys)] == $past(ram_rd);
    endproperty
    a_protect: assert property (p_protect) else $error("rejected write changed RAM");

    property p_wrap;
        ind_step && !offline && wp_inc == s_r.limit_p && !(s_r.st == ST_EXEC && !wr_q)
            |=> queue_write_pointer == $past(s_r.begin_p);
    endproperty
    a_wrap: assert property (p_wrap) else $error("write pointer did not wrap");

    property p_ready;
        s_r.st == ST_EXEC |=> !access_ready_n ##1 (!access_ready_n || s_r.st == ST_IDLE);
    endproperty
    a_ready: assert property (p_ready) else $error("ready not returned");

    property p_node_pa;
        pa_q && ram[fbr_pkg::OFS_NODE_ADDR] == fbr_pkg::NODE_PA_TEMP_DEF
            ##1 $stable(pa_q) |-> node_class == 3'h2;
    endproperty
    a_node_pa: assert property (p_node_pa) else $error("temporary default not classed");

    property p_node_dp;
        !pa_q && ram[fbr_pkg::OFS_NODE_ADDR] == fbr_pkg::NODE_DP_ASSIGN
            ##1 $stable(pa_q) |-> node_class == 3'h4;
    endproperty
    a_node_dp: assert property (p_node_dp) else $error("assignment default not classed");

    property p_queue_start;
        !ext_q && s_r.begin_p == 8'h30 ##1 !ext_q |-> queue_place_error;
    endproperty
    a_queue_start: assert property (p_queue_start) else $error("early queue start missed");

endmodule : fbr_ram_block

// >>> fbr_host.sv
// Purpose: Host processor model on the parallel port.
// Assumes: Pins change at the falling edge and stay until ready.
// Notes:   Released data and address pins show inverted patterns.
`timescale 1ns/1ps
module fbr_host (
    input  wire logic       ref_clk,
    input  wire logic       access_ready_n,
    output logic            chip_select_n,
    output logic            rd_n,
    output logic            wr_n,
    output logic      [9:0] addr,
    output logic      [7:0] data_in
);
    // ==========================================================
    // Byte access
    // ==========================================================
    // Idle pins at time zero so the device never sees a float.
    initial begin
        chip_select_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        addr = 10'h3FF;
        data_in = 8'hA5;
    end

    // One access; ok stays low when ready never comes.
    task automatic access(input logic wr, input logic [9:0] a,
                          input logic [7:0] d, output logic ok);
        int n;
        ok = 1'b0;
        @(negedge ref_clk);
        chip_select_n = 1'b0;
        addr = a;
        data_in = wr ? d : ~d;
        wr_n = ~wr;
        rd_n = wr;
        for (n = 0; n < 20 && !ok; n++) begin
            @(posedge ref_clk);
            ok = (access_ready_n === 1'b0);
        end
        @(negedge ref_clk);
        chip_select_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        addr = ~addr;
        data_in = ~data_in;
        for (n = 0; n < 20 && access_ready_n !== 1'b1; n++) @(posedge ref_clk);
        // A ready that never returns high counts as a failed access as well.
        ok = ok && (access_ready_n === 1'b1);
        @(posedge ref_clk);
    endtask : access
endmodule : fbr_host

// >>> fieldbus_ram_parameter_layout_test.sv
// Purpose: Self-checking bench for the RAM parameter block.
// Assumes: Host model waits for ready on every access.
// Notes:   Reads are scored by a watcher when data_oe rises.
`timescale 1ns/1ps
module fieldbus_ram_parameter_layout_test;
    logic       ref_clk = 1'b0;
    logic       nrst = 1'b0;
    logic       chip_select_n, rd_n, wr_n, access_ready_n, data_oe;
    logic [9:0] addr;
    logic [7:0] data_in, data_out, queue_write_pointer;
    logic       extended_mode = 1'b0, pa_variant = 1'b0;
    logic       ind_step = 1'b0, online_req = 1'b0;
    logic       write_violation, offline, queue_place_error, sap_access;
    logic [2:0] node_class;
    logic [7:0] exp_q[$];
    logic       oe_q = 1'b0;
    logic [7:0] pv[8];
    int         errors = 0, checks = 0, viol_n = 0;

    always #4 ref_clk = ~ref_clk;

    fbr_ram_block dut_u (.ref_clk, .nrst, .chip_select_n, .rd_n, .wr_n, .addr,
        .data_in, .extended_mode, .pa_variant, .ind_step, .online_req, .data_out,
        .data_oe, .access_ready_n, .queue_write_pointer, .write_violation,
        .offline, .node_class, .queue_place_error, .sap_access);
    fbr_host host_u (.ref_clk, .access_ready_n, .chip_select_n, .rd_n, .wr_n,
        .addr, .data_in);

    // ==========================================================
    // Scoring
    // ==========================================================
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic final_report;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    // Oldest noted read value is taken off when a read answer appears.
    always @(posedge ref_clk) begin
        if (data_oe === 1'b1 && !oe_q && exp_q.size() > 0)
            check("read data", data_out, exp_q.pop_front());
        oe_q <= (data_oe === 1'b1);
        if (write_violation === 1'b1) viol_n <= viol_n + 1;
    end

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        logic ok;
        host_u.access(1'b1, a, d, ok);
        if (!ok) begin
            errors++;
            final_report();
        end
    endtask : wr

    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        logic ok;
        exp_q.push_back(e);
        host_u.access(1'b0, a, e, ok);
        if (!ok) begin
            errors++;
            final_report();
        end
    endtask : rd

    task automatic pulse(ref logic s);
        @(negedge ref_clk) s = 1'b1;
        @(negedge ref_clk) s = 1'b0;
        repeat (2) @(negedge ref_clk);
    endtask : pulse

    // ==========================================================
    // Main sequence
    // ==========================================================
    // Reads go through rd, which notes the expected byte before the access.
    // Placement entries: bit 9 extended mode, bit 8 expected error, low byte begin.
    initial begin
        logic [9:0] qp[4] = '{10'h130, 10'h031, 10'h318, 10'h219};
        logic [15:0] nc[11] = '{16'h1000, 16'h1770, 16'h1781, 16'h17C1, 16'h17D2,
            16'h17E3, 16'h17F5, 16'h07D0, 16'h07E4, 16'h07F5, 16'h0030};
        logic [9:0] sa[5] = '{10'h018, 10'h031, 10'h041, 10'h180, 10'h181};
        logic [7:0] d, wpx[3] = '{8'h32, 8'h31, 8'h32};
        int v;
        void'($urandom(32'hD1DC));
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk) nrst = 1'b1;
        check("offline", {7'h00, offline}, 8'h01);
        for (int i = 0; i < 4; i++) begin
            @(negedge ref_clk) extended_mode = qp[i][9];
            wr(10'h320, qp[i][7:0]);
            repeat (3) @(negedge ref_clk);
            check("place error", {7'h00, queue_place_error}, {7'h00, qp[i][8]});
        end
        $display("test placement done");
        @(negedge ref_clk) extended_mode = 1'b0;
        wr(10'h320, 8'h31);
        wr(10'h321, 8'h33);
        wr(10'h001, 8'h31);
        pulse(online_req);
        check("offline", {7'h00, offline}, 8'h00);
        for (int i = 0; i < 3; i++) begin
            pulse(ind_step);
            check("write pointer", queue_write_pointer, wpx[i]);
        end
        $display("test queue done");
        foreach (nc[i]) begin
            @(negedge ref_clk) pa_variant = nc[i][12];
            wr(10'h004, nc[i][11:4]);
            repeat (4) @(negedge ref_clk);
            check("node class", {5'h00, node_class}, {5'h00, nc[i][2:0]});
        end
        $display("test node class done");
        @(negedge ref_clk) extended_mode = 1'b1;
        repeat (4) @(negedge ref_clk);
        v = viol_n;
        for (int a = 5; a < 8; a++) begin
            pv[a] = 8'($urandom());
            wr(10'(a), pv[a]);
            rd(10'(a), pv[a]);
        end
        foreach (sa[i]) begin
            d = 8'($urandom());
            wr(sa[i], d);
            check("sap flag", {7'h00, sap_access}, {7'h00, sa[i] <= 10'h180});
            rd(sa[i], d);
        end
        check("violations", 8'(viol_n - v), 8'h00);
        $display("test parameters done");
        @(negedge ref_clk) extended_mode = 1'b0;
        repeat (4) @(negedge ref_clk);
        wr(10'h006, ~pv[6]);
        check("offline", {7'h00, offline}, 8'h01);
        rd(10'h006, pv[6]);
        @(negedge ref_clk) extended_mode = 1'b1;
        wr(10'h008, 8'h5A);
        wr(10'h017, 8'hA5);
        check("violations", 8'(viol_n - v), 8'h03);
        $display("test protection done");
        check("pending reads", 8'(exp_q.size()), 8'h00);
        final_report();
    end
endmodule : fieldbus_ram_parameter_layout_test
